// file: logic/countdown_timer_pkg.sv
// Purpose: shared constants and types for the millisecond countdown timer
// Assumes: byte-wide register port, 25 MHz core clock
// Notes: timing counts derive from times named in their own units
package countdown_timer_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_RELOAD_LO = 8'hA0; // Reload value, low byte
    localparam logic [7:0] ADDR_RELOAD_HI = 8'hA1; // Reload value, high byte
    localparam logic [7:0] ADDR_EVENT_SRC = 8'hA2; // Event source register
    localparam logic [7:0] ADDR_CONTROL = 8'hA3; // Control register
    localparam logic [7:0] ADDR_COUNT_LO = 8'hA4; // Count readback, low byte
    localparam logic [7:0] ADDR_COUNT_HI = 8'hA5; // Count readback, high byte

    // Field positions
    localparam int BIT_UFLOW = 0; // Underflow flag in event source
    localparam int BIT_ENABLE = 0; // Run enable in control
    localparam int BIT_RESET = 1; // Self-clearing reset in control
    localparam int BIT_STOP = 2; // Stop at underflow in control
    localparam int BIT_STATUS = 7; // Running status in control

    // Reset values and other fixed constants
    localparam logic [15:0] RELOAD_RESET = 16'hFFFF; // Reload after reset
    localparam logic [15:0] COUNT_RESET = 16'h0000; // Count after reset
    localparam logic [7:0] BYTE_ZERO = 8'h00; // Empty read byte
    localparam logic [15:0] COUNT_ONE = 16'h0001; // Last count before underflow

    // Timing
    localparam int CLOCK_PERIOD_NS = 40; // Core clock period
    localparam int TICK_PERIOD_US = 1000; // One count per millisecond
    localparam int SETTLE_TIME_US = 200; // Halt and reset propagation time
    localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLOCK_PERIOD_NS;
    localparam int SETTLE_CYCLES = SETTLE_TIME_US * 1000 / CLOCK_PERIOD_NS;

    // Register port request
    typedef struct packed {
        logic write; // One-cycle write strobe
        logic read; // One-cycle read strobe
        logic [7:0] addr; // Byte address
        logic [7:0] wdata; // Write byte
    } reg_req_t;

endpackage : countdown_timer_pkg

// file: logic/ms_tick_gen.sv
// Purpose: millisecond tick pulse for the countdown timer
// Assumes: run is from the same clock domain
// Notes: the phase restarts whenever run drops
`timescale 1ns/10ps
`default_nettype none
module ms_tick_gen
    import countdown_timer_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES // Clock cycles per tick
) (
    input wire logic clock, // Core clock
    input wire logic reset_n, // Synchronised reset, active low
    input wire logic run, // Count while high
    output logic tick // One-cycle pulse each period
);

    typedef struct packed {
        logic [15:0] phase; // Cycles into the period
        logic tick; // Registered pulse
    } tick_state_t;

    tick_state_t state; // Present state
    tick_state_t next_state; // Next state

    // Advance the phase and fire at the period end
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (!run) begin
            next_state.phase = '0;
        end else if (state.phase == 16'(TICK_LEN - 1)) begin
            next_state.phase = '0;
            next_state.tick = 1'b1;
        end else begin
            next_state.phase = state.phase + 16'h0001;
        end
    end

    // State register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule : ms_tick_gen
`default_nettype wire

// file: logic/countdown_timer.sv
// Overview of operation
// R1 - Underflow sets event source bit zero
// R2 - Interrupt output follows underflow flag
// R3 - Stop mode delays flag until halted
// R4 - Control bit seven shows running state
// R5 - Stop mode clears enable at underflow
// R6 - Reset bit stops and reloads counter
// R7 - Reset bit self-clears after propagation time
// R8 - Enable starts or pauses, keeps count
// R9 - Count readback returns count, ignores writes
// R10 - Software disables timer before reading count
// R11 - Flag resets to zero, software clears
// R12 - Counts down from reload each millisecond
// R13 - Software never programs zero reload
// R14 - Software leaves reload alone during reset
// R15 - Free mode reloads and keeps counting
// R16 - Writing one clears flag, zero ignored
//
// Purpose: millisecond countdown timer with control, event and readback registers
// Assumes: byte register port on the core clock; strobes last one cycle
// Notes: read data appears the cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
module countdown_timer
    import countdown_timer_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES, // Cycles per millisecond
    parameter int SETTLE_LEN = SETTLE_CYCLES // Cycles of halt or reset settling
) (
    input wire logic clock, // Core clock, 25 MHz
    input wire logic reset_n, // Asynchronous reset, active low
    input wire reg_req_t req, // Register port request
    output logic [7:0] rd_data, // Registered read byte
    output logic countdown_irq // Timer interrupt level
);

    // Whole state of the timer
    typedef struct packed {
        logic enable; // Run enable bit
        logic stop_at_underflow; // Halt on underflow
        logic reset_busy; // Self-clearing reset in progress
        logic halt_pending; // Halt settling after underflow
        logic underflow_flag; // Sticky underflow event
        logic [15:0] settle; // Settling countdown
        logic [15:0] count; // Present counter value
        logic [15:0] reload; // Reload value register
        logic [7:0] rd_data; // Read byte
    } timer_state_t;

    timer_state_t state; // Present state
    timer_state_t next_state; // Next state
    logic rst_meta; // Reset release, first stage
    logic rst_sync_n; // Reset release, synchronised
    logic running; // Status bit value
    logic tick; // Millisecond pulse
    logic step; // Tick taken while counting
    logic underflow; // Underflow event this cycle
    logic settle_done; // Settling countdown expired
    logic wr_src; // Write to event source
    logic wr_ctl; // Write to control
    logic ctl_reset; // Control write asks for reset
    logic flag_clear; // Software clear of flag

    // Decode a write to one address
    function automatic logic hit(input reg_req_t r, input logic [7:0] a);
        hit = r.write && (r.addr == a);
    endfunction : hit

    // Release reset through two flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // R4 status while counting or halting
    assign running = (state.enable && !state.reset_busy) || state.halt_pending;

    // Millisecond pulse source
    ms_tick_gen #(
        .TICK_LEN(TICK_LEN)
    ) u_tick (
        .clock(clock),
        .reset_n(rst_sync_n),
        .run(state.enable && !state.reset_busy),
        .tick(tick)
    );

    // Late tick after a disable or reset write is dropped
    assign step = tick && state.enable && !state.reset_busy;
    // R12 underflow at last count
    assign underflow = step && (state.count <= COUNT_ONE);
    // Settling and register write decodes
    assign settle_done = (state.settle == '0);
    assign wr_src = hit(req, ADDR_EVENT_SRC);
    assign wr_ctl = hit(req, ADDR_CONTROL);
    assign ctl_reset = wr_ctl && req.wdata[BIT_RESET];
    // R16 only a one clears
    assign flag_clear = wr_src && req.wdata[BIT_UFLOW];

    // Next-state logic
    always_comb begin
        // Hold everything by default
        next_state = state;
        // Software clear, set below wins
        if (flag_clear) begin
            next_state.underflow_flag = 1'b0;
        end
        // Reload value writes
        if (hit(req, ADDR_RELOAD_LO)) begin
            next_state.reload[7:0] = req.wdata;
        end
        if (hit(req, ADDR_RELOAD_HI)) begin
            next_state.reload[15:8] = req.wdata;
        end
        // R8 enable without touching count
        if (wr_ctl) begin
            next_state.enable = req.wdata[BIT_ENABLE];
            next_state.stop_at_underflow = req.wdata[BIT_STOP];
        end
        // Settling countdown
        if (!settle_done) begin
            next_state.settle = state.settle - 16'h0001;
        end
        // Counting
        if (step) begin
            if (underflow) begin
                // R15 reload; continue unless stop mode
                next_state.count = state.reload;
                if (state.stop_at_underflow) begin
                    // R5 auto stop clears enable
                    next_state.enable = 1'b0;
                    next_state.halt_pending = 1'b1;
                    next_state.settle = 16'(SETTLE_LEN - 1);
                end else begin
                    // R1 flag on underflow
                    next_state.underflow_flag = 1'b1;
                end
            end else begin
                next_state.count = state.count - 16'h0001;
            end
        end
        // R3 flag once fully halted
        if (state.halt_pending && settle_done) begin
            next_state.halt_pending = 1'b0;
            next_state.underflow_flag = 1'b1;
        end
        // R7 reset clears after settling
        if (state.reset_busy && settle_done) begin
            next_state.reset_busy = 1'b0;
        end
        // R6 reset stops and reloads
        if (ctl_reset) begin
            next_state.enable = 1'b0;
            next_state.reset_busy = 1'b1;
            next_state.count = state.reload;
            next_state.settle = 16'(SETTLE_LEN - 1);
            // Pending underflow is not lost
            if (state.halt_pending) begin
                next_state.halt_pending = 1'b0;
                next_state.underflow_flag = 1'b1;
            end
        end
        // Read mux, R9 count is read only
        if (req.read) begin
            unique case (req.addr)
                ADDR_RELOAD_LO: next_state.rd_data = state.reload[7:0];
                ADDR_RELOAD_HI: next_state.rd_data = state.reload[15:8];
                ADDR_EVENT_SRC: begin
                    next_state.rd_data = BYTE_ZERO;
                    next_state.rd_data[BIT_UFLOW] = state.underflow_flag;
                end
                ADDR_CONTROL: begin
                    next_state.rd_data = BYTE_ZERO;
                    next_state.rd_data[BIT_ENABLE] = state.enable;
                    next_state.rd_data[BIT_RESET] = state.reset_busy;
                    next_state.rd_data[BIT_STOP] = state.stop_at_underflow;
                    next_state.rd_data[BIT_STATUS] = running;
                end
                ADDR_COUNT_LO: next_state.rd_data = state.count[7:0];
                ADDR_COUNT_HI: next_state.rd_data = state.count[15:8];
                // Unmapped places read zero
                default: next_state.rd_data = BYTE_ZERO;
            endcase
        end
    end

    // State register, R11 flag resets low
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= '0;
            state.reload <= RELOAD_RESET;
            state.count <= COUNT_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Read byte straight from its flop
    assign rd_data = state.rd_data;
    // R2 interrupt follows flag
    assign countdown_irq = state.underflow_flag;

    // Checks run on the core clock, quiet in reset
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_sync_n);

    // R1 free-running underflow
    uflow_free_a: assert property (underflow && !state.stop_at_underflow |=> // R1
        state.underflow_flag && state.count == $past(state.reload))
        else $error("free-running underflow did not set flag");

    // R1 set beats clear
    clear_race_a: assert property (underflow && !state.stop_at_underflow && flag_clear // R1
        |=> state.underflow_flag)
        else $error("software clear hid an underflow");

    // R2 interrupt holds
    irq_hold_a: assert property (state.underflow_flag && !flag_clear |=> // R2
        countdown_irq)
        else $error("interrupt dropped without clear");

    // R3 flag waits for halt
    halt_wait_a: assert property (state.halt_pending && !settle_done && !ctl_reset // R3
        && !state.underflow_flag |=> !state.underflow_flag)
        else $error("flag raised before halt completed");

    // R4 status drops with flag
    status_halt_a: assert property (state.halt_pending && settle_done && !state.enable // R4
        && !wr_ctl |=> !running && state.underflow_flag)
        else $error("halt did not end with status low and flag set");

    // R5 stop mode clears enable
    stop_clear_a: assert property (underflow && state.stop_at_underflow && !ctl_reset // R5
        |=> !state.enable && state.halt_pending)
        else $error("stop mode did not clear enable");

    // R6 reset reloads count
    reset_reload_a: assert property (ctl_reset |=> state.reset_busy && !running // R6
        && state.count == $past(state.reload))
        else $error("reset did not stop and reload");

    // R6 reset bit reads one
    reset_read_a: assert property (req.read && req.addr == ADDR_CONTROL && state.reset_busy // R6
        |=> rd_data[BIT_RESET])
        else $error("reset bit read low while busy");

    // R7 reset bit holds
    reset_hold_a: assert property (state.reset_busy && !settle_done |=> // R7
        state.reset_busy)
        else $error("reset bit cleared early");

    // R8 enable write keeps count
    enable_keep_a: assert property (wr_ctl && !ctl_reset && !tick |=> // R8
        state.count == $past(state.count))
        else $error("enable write changed count");

    // R8 paused count holds
    count_hold_a: assert property (!state.enable && !ctl_reset |=> // R8
        $stable(state.count))
        else $error("count moved while paused");

    // R9 count not writable
    count_ro_a: assert property (hit(req, ADDR_COUNT_LO) && !tick && !ctl_reset // R9
        |=> state.count == $past(state.count))
        else $error("count register accepted a write");

    // R9 count reads back
    count_read_a: assert property (req.read && req.addr == ADDR_COUNT_HI |=> // R9
        rd_data == $past(state.count[15:8]))
        else $error("count high byte read wrong");

    // R11 flag reads back
    flag_read_a: assert property (req.read && req.addr == ADDR_EVENT_SRC |=> // R11
        rd_data[BIT_UFLOW] == $past(state.underflow_flag))
        else $error("flag read wrong");

    // R12 one count per tick
    count_step_a: assert property (step && !underflow && !ctl_reset |=> // R12
        state.count == $past(state.count) - 16'h0001)
        else $error("tick did not count down by one");

    // R16 zero write keeps flag
    clear_zero_a: assert property (wr_src && !req.wdata[BIT_UFLOW] // R16
        && state.underflow_flag |=> state.underflow_flag)
        else $error("writing zero cleared flag");

    // Main scenarios reached
    free_uflow_c: cover property (underflow && !state.stop_at_underflow);
    halt_done_c: cover property (state.halt_pending && settle_done);
    reset_done_c: cover property (state.reset_busy && settle_done);
    flag_clear_c: cover property (flag_clear && state.underflow_flag);
    pause_c: cover property (wr_ctl && !req.wdata[BIT_ENABLE] && state.enable);

endmodule : countdown_timer
`default_nettype wire

// file: verification/countdown_timer_tb.sv
// Purpose: self-checking bench for the millisecond countdown timer
// Assumes: short tick and settle lengths so each run stays brief
// Notes: register port driven 1 ns after the rising edge
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import countdown_timer_pkg::*;
    localparam int TICK = 10; // Cycles per count
    localparam int SETTLE = 4; // Halt and reset settling cycles
    logic clock = 1'b0; // Core clock, 40 ns period
    logic reset_n = 1'b0; // Reset, active low
    reg_req_t req = '0; // Register port request
    logic [7:0] rd_data; // Read byte from the timer
    logic countdown_irq; // Timer interrupt level
    int miscompares = 0; // Mismatches seen
    int checks_done = 0; // Comparisons made
    int cycles = 0; // Watchdog cycle count
    int t_free; // Cycles to flag, free running
    int t_stop; // Cycles to flag, stop mode
    logic [7:0] got; // Last byte read

    // Timer under test with short counts
    countdown_timer #(.TICK_LEN(TICK), .SETTLE_LEN(SETTLE)) dut (
        .clock(clock),
        .reset_n(reset_n),
        .req(req),
        .rd_data(rd_data),
        .countdown_irq(countdown_irq)
    );

    // Clock toggles every half period
    always #20 clock = ~clock;

    // Watchdog cuts a hang short
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end

    // Verdict and end of run
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // Byte comparison
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check8

    // Interrupt level comparison
    task automatic check1(input string name, input logic exp);
        checks_done++;
        if (countdown_irq !== exp) begin
            miscompares++;
            $display("ERROR %s expected %b seen %b", name, exp, countdown_irq);
        end
    endtask : check1

    // Cycle count within a window
    task automatic check_span(input string name, input int lo, input int hi, input int seen);
        checks_done++;
        if (seen < lo || seen > hi) begin
            miscompares++;
            $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, seen);
        end
    endtask : check_span

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 req = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        #1 req = '0;
    endtask : wr

    // One-cycle read strobe, data follows that edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        #1 req = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        #1 req = '0;
        v = rd_data;
    endtask : rd

    // Bounded wait for the interrupt
    task automatic wait_irq(output int n);
        n = 0;
        while (countdown_irq !== 1'b1 && n < 200) begin
            @(posedge clock);
            #1 n++;
        end
    endtask : wait_irq

    // Values straight after reset, unmapped place
    task automatic test_reset_values();
        rd(ADDR_EVENT_SRC, got); check8("flag after reset", 8'h00, got);
        rd(ADDR_CONTROL, got); check8("control after reset", 8'h00, got);
        rd(ADDR_COUNT_LO, got); check8("count lo after reset", 8'h00, got);
        rd(ADDR_COUNT_HI, got); check8("count hi after reset", 8'h00, got);
        rd(ADDR_RELOAD_HI, got); check8("reload hi after reset", 8'hFF, got);
        rd(8'h10, got); check8("unmapped read", 8'h00, got);
        check1("irq after reset", 1'b0);
    endtask : test_reset_values

    // Reset bit loads reload, clears itself, count ignores writes
    task automatic test_reset_bit();
        wr(ADDR_RELOAD_LO, 8'h03);
        wr(ADDR_RELOAD_HI, 8'h00);
        wr(ADDR_CONTROL, 8'h02);
        rd(ADDR_CONTROL, got); check8("reset bit held", 8'h02, got);
        repeat (2 * SETTLE) @(posedge clock);
        rd(ADDR_CONTROL, got); check8("reset bit cleared", 8'h00, got);
        wr(ADDR_COUNT_LO, 8'h55);
        rd(ADDR_COUNT_LO, got); check8("count reloaded", 8'h03, got);
        rd(ADDR_COUNT_HI, got); check8("count hi reloaded", 8'h00, got);
    endtask : test_reset_bit

    // Free running underflow, flag persistence, clear by one
    task automatic test_free_run();
        wr(ADDR_CONTROL, 8'h01);
        rd(ADDR_CONTROL, got); check8("running status", 8'h81, got);
        wait_irq(t_free);
        check_span("free underflow time", 3 * TICK - 4, 3 * TICK + 2, t_free);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_COUNT_LO, got); check8("free reload", 8'h03, got);
        rd(ADDR_EVENT_SRC, got); check8("flag set", 8'h01, got);
        repeat (20) @(posedge clock);
        check1("irq persists", 1'b1);
        wr(ADDR_EVENT_SRC, 8'h00);
        check1("zero write keeps flag", 1'b1);
        wr(ADDR_EVENT_SRC, 8'h01);
        check1("irq dropped", 1'b0);
        rd(ADDR_EVENT_SRC, got); check8("flag cleared", 8'h00, got);
    endtask : test_free_run

    // Stop mode clears enable and delays the flag
    task automatic test_stop_mode();
        wr(ADDR_CONTROL, 8'h05);
        rd(ADDR_CONTROL, got); check8("stop mode running", 8'h85, got);
        wait_irq(t_stop);
        check_span("delayed flag", t_free + SETTLE - 1, t_free + SETTLE + 1, t_stop);
        rd(ADDR_CONTROL, got); check8("halted control", 8'h04, got);
        rd(ADDR_COUNT_LO, got); check8("stop reload", 8'h03, got);
        wr(ADDR_EVENT_SRC, 8'h01);
    endtask : test_stop_mode

    // Pause keeps the count
    task automatic test_pause();
        wr(ADDR_CONTROL, 8'h01);
        repeat (TICK + 5) @(posedge clock);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_COUNT_LO, got); check8("paused count", 8'h02, got);
        repeat (3 * TICK) @(posedge clock);
        rd(ADDR_COUNT_LO, got); check8("count held", 8'h02, got);
        check1("no irq while paused", 1'b0);
    endtask : test_pause

    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clock);
        test_reset_values();
        test_reset_bit();
        test_free_run();
        test_stop_mode();
        test_pause();
        conclude();
    end
endmodule : testbench
`default_nettype wire
